// ### verilog/scl_loader.sv
// Operation
// - The block works only while master select is high; open pin reads high.
// - The serial data output floats whenever master select is low.
// - The block makes the memory clock and floats it while deselected.
// - The block drives memory select and floats it while deselected.
// - Serial data from memory load the coefficients; ignored while deselected.
// - Temperature data are shifted out on the serial data output.
// - The memory holds 4096 bits; each coefficient is one 16-bit word.
// - Five 16-bit coefficient outputs are loaded from memory words.
// - One memory word goes unchanged into the offset coefficient.
// - Amplifier gain is one of eight settings, 54 to 306 V/V.
// - One memory word goes unchanged into the span coefficient.
// - Memory words load both the offset and span temperature coefficients.
// - Up to 120 temperature points, each one offset and one span word.
// - The 12-bit bridge drive reading picks the memory address of the pair.
// - One memory word goes unchanged into the linearity coefficient.
// - A nominal 100 kHz oscillator paces the logic and drives its own output.
// - Coefficients are refreshed from memory about three times a second.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module scl_loader #(
  parameter int REFRESH_OSC_CYC = scl_pkg::REFRESH_OSC_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory link.
  input wire logic master_select,
  input wire logic eeprom_serial_in,
  output logic eeprom_serial_out,
  output logic eeprom_serial_out_oe,
  output logic eeprom_clock_out,
  output logic eeprom_clock_out_oe,
  output logic eeprom_select_out,
  output logic eeprom_select_out_oe,
  output logic oscillator_out,
  // Bridge drive conversion.
  input wire logic [11:0] bridge_code,
  input wire logic bridge_code_valid,
  // Coefficients.
  output logic [15:0] offset_dac,
  output logic [15:0] span_dac,
  output logic [15:0] offset_tempco_dac,
  output logic [15:0] span_tempco_dac,
  output logic [15:0] linearity_dac,
  output logic [2:0] gain_sel
);

  typedef enum logic [2:0] {
    LD_IDLE = 3'b001,
    LD_WAIT = 3'b010,
    LD_DUMP = 3'b100
  } scl_ld_e;

  // Segment index: code * 120 / 4096, so the top code lands on 119.
  function automatic logic [6:0] seg_of(input logic [11:0] code);
    logic [18:0] p;
    p = 19'(code) * 19'(scl_pkg::SEG_NUM);
    return p[18:12];
  endfunction

  function automatic logic [7:0] addr_of(input logic [2:0] idx, input logic [6:0] seg);
    logic [7:0] a;
    a = scl_pkg::EE_CFG_ADDR;
    unique case (idx)
      scl_pkg::W_OFS: a = scl_pkg::EE_OFS_ADDR;
      scl_pkg::W_SPN: a = scl_pkg::EE_SPN_ADDR;
      scl_pkg::W_LIN: a = scl_pkg::EE_LIN_ADDR;
      scl_pkg::W_OTC: a = scl_pkg::EE_TC_BASE + {seg, 1'b0};
      scl_pkg::W_STC: a = scl_pkg::EE_TC_BASE + {seg, 1'b0} + 8'h01;
      default: a = scl_pkg::EE_CFG_ADDR;
    endcase
    return a;
  endfunction

  scl_ld_e st_reg, st_next;
  logic sel_s1_reg, sel_reg;
  logic sdi_s1_reg, sdi_reg;
  logic ctrl_en_reg, ctrl_en_next;
  logic pending_reg, pending_next;
  logic done_flag_reg, done_flag_next;
  logic [scl_pkg::REFR_W-1:0] refr_reg, refr_next;
  logic [2:0] widx_reg, widx_next;
  logic [11:0] temp_reg, temp_next;
  logic [6:0] seg_reg, seg_next;
  logic [15:0] ofs_reg, ofs_next;
  logic [15:0] spn_reg, spn_next;
  logic [15:0] otc_reg, otc_next;
  logic [15:0] stc_reg, stc_next;
  logic [15:0] lin_reg, lin_next;
  logic [2:0] gain_reg, gain_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;

  logic half_tick, period_tick;
  logic rd_start, rd_cs, rd_busy, rd_done;
  logic [11:0] rd_data;
  logic [5:0] rd_olen, rd_ilen;
  logic [15:0] rd_word;
  logic acc_wr;
  logic [6:0] seg_now;

  scl_osc #(
    .HALF_CYC(scl_pkg::OSC_HALF_CYC)
  ) u_osc (
    .clk(pclk),
    .rst_n(presetn),
    .half_tick(half_tick),
    .period_tick(period_tick),
    .osc_out(oscillator_out)
  );

  // Deselect aborts the shifter, so the bus goes quiet one clock after the pins float.
  scl_serial u_ser (
    .clk(pclk),
    .rst_n(presetn),
    .tick(half_tick),
    .abort(~sel_reg),
    .start(rd_start),
    .use_cs(rd_cs),
    .out_data(rd_data),
    .out_len(rd_olen),
    .in_len(rd_ilen),
    .busy(rd_busy),
    .done(rd_done),
    .word(rd_word),
    .sdi(sdi_reg),
    .sck(eeprom_clock_out),
    .cs(eeprom_select_out),
    .sdo(eeprom_serial_out)
  );

  assign seg_now = seg_of(temp_reg);
  assign acc_wr = psel & penable & pready_reg & pwrite;

  always_comb begin
    st_next = st_reg;
    ctrl_en_next = ctrl_en_reg;
    pending_next = pending_reg;
    done_flag_next = done_flag_reg;
    refr_next = refr_reg;
    widx_next = widx_reg;
    temp_next = temp_reg;
    seg_next = seg_reg;
    ofs_next = ofs_reg;
    spn_next = spn_reg;
    otc_next = otc_reg;
    stc_next = stc_reg;
    lin_next = lin_reg;
    gain_next = gain_reg;
    rd_start = 1'b0;
    rd_cs = 1'b1;
    rd_data = {scl_pkg::CMD_READ, addr_of(scl_pkg::W_CFG, seg_now), 1'b0};
    rd_olen = scl_pkg::READ_OUT_LEN;
    rd_ilen = scl_pkg::READ_IN_LEN;

    // Software writes come first so that a hardware set in the same cycle wins.
    if (acc_wr && paddr == scl_pkg::REG_CTRL) begin
      ctrl_en_next = pwdata[scl_pkg::CTRL_EN_BIT];
      if (pwdata[scl_pkg::CTRL_START_BIT]) begin
        pending_next = 1'b1;
      end
    end
    if (acc_wr && paddr == scl_pkg::REG_STATUS && pwdata[scl_pkg::STAT_DONE_BIT]) begin
      done_flag_next = 1'b0;
    end

    if (bridge_code_valid) begin
      temp_next = bridge_code;
    end

    if (period_tick) begin
      if (refr_reg == scl_pkg::REFR_W'(REFRESH_OSC_CYC - 1)) begin
        refr_next = '0;
        if (ctrl_en_reg) begin
          pending_next = 1'b1;
        end
      end else begin
        refr_next = refr_reg + 1'b1;
      end
    end

    unique case (st_reg)
      LD_IDLE: begin
        if (pending_reg && sel_reg && !rd_busy) begin
          pending_next = 1'b0;
          widx_next = scl_pkg::W_CFG;
          seg_next = seg_now;
          rd_start = 1'b1;
          st_next = LD_WAIT;
        end
      end
      LD_WAIT: begin
        if (rd_done) begin
          unique case (widx_reg)
            scl_pkg::W_CFG: gain_next = rd_word[scl_pkg::GAIN_W-1:0];
            scl_pkg::W_OFS: ofs_next = rd_word;
            scl_pkg::W_SPN: spn_next = rd_word;
            scl_pkg::W_LIN: lin_next = rd_word;
            scl_pkg::W_OTC: otc_next = rd_word;
            scl_pkg::W_STC: stc_next = rd_word;
            default: gain_next = gain_reg;
          endcase
          if (widx_reg == scl_pkg::W_STC) begin
            rd_start = 1'b1;
            rd_cs = 1'b0;
            rd_data = temp_reg;
            rd_olen = scl_pkg::DUMP_OUT_LEN;
            rd_ilen = 6'h00;
            st_next = LD_DUMP;
          end else begin
            widx_next = widx_reg + 1'b1;
            rd_start = 1'b1;
            rd_data = {scl_pkg::CMD_READ, addr_of(widx_reg + 1'b1, seg_reg), 1'b0};
          end
        end
      end
      LD_DUMP: begin
        if (rd_done) begin
          done_flag_next = 1'b1;
          st_next = LD_IDLE;
        end
      end
      default: st_next = LD_IDLE;
    endcase

    // A refresh cut short by deselect is retried once the block is selected.
    if (!sel_reg) begin
      rd_start = 1'b0;
      st_next = LD_IDLE;
      if (st_reg != LD_IDLE) begin
        pending_next = 1'b1;
      end
    end
  end

  // Read data are taken in the setup cycle, so the bus answers with no wait.
  always_comb begin
    pready_next = psel & ~penable;
    pslverr_next = 1'b0;
    prdata_next = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        scl_pkg::REG_CTRL: prdata_next = {31'h0000_0000, ctrl_en_reg};
        scl_pkg::REG_STATUS: prdata_next = {17'h0_0000, seg_reg, 5'h00, done_flag_reg,
          sel_reg, (st_reg != LD_IDLE)};
        scl_pkg::REG_GAIN: prdata_next = {29'h0000_0000, gain_reg};
        scl_pkg::REG_OFFSET: prdata_next = {16'h0000, ofs_reg};
        scl_pkg::REG_SPAN: prdata_next = {16'h0000, spn_reg};
        scl_pkg::REG_OFFSET_TC: prdata_next = {16'h0000, otc_reg};
        scl_pkg::REG_SPAN_TC: prdata_next = {16'h0000, stc_reg};
        scl_pkg::REG_LIN: prdata_next = {16'h0000, lin_reg};
        scl_pkg::REG_TEMP: prdata_next = {20'h0_0000, temp_reg};
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  // The first stage of each synchroniser feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_s1_reg <= 1'b0;
      sel_reg <= 1'b0;
      sdi_s1_reg <= 1'b0;
      sdi_reg <= 1'b0;
    end else begin
      sel_s1_reg <= master_select;
      sel_reg <= sel_s1_reg;
      sdi_s1_reg <= eeprom_serial_in;
      sdi_reg <= sdi_s1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= LD_IDLE;
      ctrl_en_reg <= scl_pkg::CTRL_EN_RST;
      pending_reg <= 1'b1;
      done_flag_reg <= 1'b0;
      refr_reg <= '0;
      widx_reg <= scl_pkg::W_CFG;
      temp_reg <= '0;
      seg_reg <= '0;
      ofs_reg <= scl_pkg::COEF_RST;
      spn_reg <= scl_pkg::COEF_RST;
      otc_reg <= scl_pkg::COEF_RST;
      stc_reg <= scl_pkg::COEF_RST;
      lin_reg <= scl_pkg::COEF_RST;
      gain_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      ctrl_en_reg <= ctrl_en_next;
      pending_reg <= pending_next;
      done_flag_reg <= done_flag_next;
      refr_reg <= refr_next;
      widx_reg <= widx_next;
      temp_reg <= temp_next;
      seg_reg <= seg_next;
      ofs_reg <= ofs_next;
      spn_reg <= spn_next;
      otc_reg <= otc_next;
      stc_reg <= stc_next;
      lin_reg <= lin_next;
      gain_reg <= gain_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign eeprom_serial_out_oe = sel_reg;
  assign eeprom_clock_out_oe = sel_reg;
  assign eeprom_select_out_oe = sel_reg;
  assign offset_dac = ofs_reg;
  assign span_dac = spn_reg;
  assign offset_tempco_dac = otc_reg;
  assign span_tempco_dac = stc_reg;
  assign linearity_dac = lin_reg;
  assign gain_sel = gain_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

// ### inc/scl_pkg.sv
package scl_pkg;

  // Timing.
  localparam int CLK_HZ = 25_000_000;
  localparam int OSC_HZ = 100_000;
  localparam int REFRESH_HZ = 3;
  localparam int OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
  localparam int REFRESH_OSC_CYC = OSC_HZ / REFRESH_HZ;
  localparam int REFR_W = 16;

  // Serial memory geometry and command.
  localparam int MEM_BITS = 4096;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_READ = 3'h6;
  localparam int SH_W = 12;
  localparam int CNT_W = 6;
  localparam logic [5:0] READ_OUT_LEN = 6'h0b;
  localparam logic [5:0] READ_IN_LEN = 6'h10;
  localparam logic [5:0] DUMP_OUT_LEN = 6'h0c;

  // Word layout in the memory.
  localparam logic [7:0] EE_CFG_ADDR = 8'h00;
  localparam logic [7:0] EE_OFS_ADDR = 8'h01;
  localparam logic [7:0] EE_SPN_ADDR = 8'h02;
  localparam logic [7:0] EE_LIN_ADDR = 8'h03;
  localparam logic [7:0] EE_TC_BASE = 8'h08;

  // Fetch order.
  localparam logic [2:0] W_CFG = 3'h0;
  localparam logic [2:0] W_OFS = 3'h1;
  localparam logic [2:0] W_SPN = 3'h2;
  localparam logic [2:0] W_LIN = 3'h3;
  localparam logic [2:0] W_OTC = 3'h4;
  localparam logic [2:0] W_STC = 3'h5;

  // Temperature segments and gain.
  localparam int TEMP_W = 12;
  localparam int SEG_W = 7;
  localparam int SEG_NUM = 120;
  localparam int GAIN_W = 3;

  // Register map.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_GAIN = 12'h008;
  localparam logic [11:0] REG_OFFSET = 12'h00c;
  localparam logic [11:0] REG_SPAN = 12'h010;
  localparam logic [11:0] REG_OFFSET_TC = 12'h014;
  localparam logic [11:0] REG_SPAN_TC = 12'h018;
  localparam logic [11:0] REG_LIN = 12'h01c;
  localparam logic [11:0] REG_TEMP = 12'h020;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [15:0] COEF_RST = 16'h0000;

endpackage

// ### verilog/scl_osc.sv
`timescale 1ns/100ps
module scl_osc #(
  parameter int HALF_CYC = scl_pkg::OSC_HALF_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Enables and oscillator.
  output logic half_tick,
  output logic period_tick,
  output logic osc_out
);

  localparam int CW = $clog2(HALF_CYC);

  logic [CW-1:0] cnt_reg, cnt_next;
  logic osc_reg, osc_next;
  logic tick_reg, tick_next;
  logic per_reg, per_next;

  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    osc_next = osc_reg;
    tick_next = 1'b0;
    per_next = 1'b0;
    if (cnt_reg == CW'(HALF_CYC - 1)) begin
      cnt_next = '0;
      osc_next = ~osc_reg;
      tick_next = 1'b1;
      per_next = osc_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      osc_reg <= 1'b0;
      tick_reg <= 1'b0;
      per_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      osc_reg <= osc_next;
      tick_reg <= tick_next;
      per_reg <= per_next;
    end
  end

  assign half_tick = tick_reg;
  assign period_tick = per_reg;
  assign osc_out = osc_reg;

endmodule

// ### verilog/scl_serial.sv
`timescale 1ns/100ps
module scl_serial #(
  parameter int SH_W = scl_pkg::SH_W,
  parameter int WORD_W = scl_pkg::WORD_W,
  parameter int CNT_W = scl_pkg::CNT_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic tick,
  input wire logic abort,
  input wire logic start,
  input wire logic use_cs,
  input wire logic [SH_W-1:0] out_data,
  input wire logic [CNT_W-1:0] out_len,
  input wire logic [CNT_W-1:0] in_len,
  output logic busy,
  output logic done,
  output logic [WORD_W-1:0] word,
  // Serial lines.
  input wire logic sdi,
  output logic sck,
  output logic cs,
  output logic sdo
);

  typedef enum logic [1:0] {SR_IDLE = 2'b01, SR_RUN = 2'b10} scl_sr_e;

  scl_sr_e st_reg, st_next;
  logic [SH_W-1:0] sh_reg, sh_next;
  logic [WORD_W-1:0] in_reg, in_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] olen_reg, olen_next;
  logic [CNT_W-1:0] tot_reg, tot_next;
  logic sck_reg, sck_next;
  logic cs_reg, cs_next;
  logic done_reg, done_next;

  // Data leave on the falling clock and are sampled on the rising one.
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    in_next = in_reg;
    cnt_next = cnt_reg;
    olen_next = olen_reg;
    tot_next = tot_reg;
    sck_next = sck_reg;
    cs_next = cs_reg;
    done_next = 1'b0;
    unique case (st_reg)
      SR_IDLE: begin
        if (start) begin
          st_next = SR_RUN;
          sh_next = out_data;
          olen_next = out_len;
          tot_next = CNT_W'(out_len + in_len);
          cnt_next = '0;
          sck_next = 1'b0;
          cs_next = use_cs;
        end
      end
      SR_RUN: begin
        if (tick) begin
          if (!sck_reg) begin
            sck_next = 1'b1;
            if (cnt_reg >= olen_reg) begin
              in_next = {in_reg[WORD_W-2:0], sdi};
            end
          end else begin
            sck_next = 1'b0;
            sh_next = {sh_reg[SH_W-2:0], 1'b0};
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == tot_reg - 1'b1) begin
              st_next = SR_IDLE;
              cs_next = 1'b0;
              done_next = 1'b1;
            end
          end
        end
      end
    endcase
    if (abort) begin
      st_next = SR_IDLE;
      sh_next = '0;
      sck_next = 1'b0;
      cs_next = 1'b0;
      done_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= SR_IDLE;
      sh_reg <= '0;
      in_reg <= '0;
      cnt_reg <= '0;
      olen_reg <= '0;
      tot_reg <= '0;
      sck_reg <= 1'b0;
      cs_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      in_reg <= in_next;
      cnt_reg <= cnt_next;
      olen_reg <= olen_next;
      tot_reg <= tot_next;
      sck_reg <= sck_next;
      cs_reg <= cs_next;
      done_reg <= done_next;
    end
  end

  assign busy = (st_reg == SR_RUN);
  assign done = done_reg;
  assign word = in_reg;
  assign sck = sck_reg;
  assign cs = cs_reg;
  assign sdo = sh_reg[SH_W-1];

endmodule

// ### test/scl_loader_checker.sv
`timescale 1ns/100ps
module scl_loader_checker #(
  parameter int REFRESH_OSC_CYC = 4
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Memory link.
  input wire logic master_select,
  input wire logic eeprom_serial_out_oe,
  input wire logic eeprom_clock_out,
  input wire logic eeprom_clock_out_oe,
  input wire logic eeprom_select_out,
  input wire logic eeprom_select_out_oe,
  input wire logic oscillator_out,
  // Coefficients.
  input wire logic [15:0] offset_dac,
  input wire logic [15:0] span_dac
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Counters start saturated, so the first edge after a reset is never judged.
  logic [7:0] osc_cnt_reg;
  logic [7:0] osc_cnt_next;
  logic [7:0] eck_cnt_reg;
  logic [7:0] eck_cnt_next;
  logic osc_prev_reg;
  logic eck_prev_reg;
  always_comb begin
    osc_cnt_next = (osc_cnt_reg == 8'hff) ? 8'hff : osc_cnt_reg + 8'h01;
    eck_cnt_next = (eck_cnt_reg == 8'hff) ? 8'hff : eck_cnt_reg + 8'h01;
    if (oscillator_out != osc_prev_reg)
      osc_cnt_next = 8'h01;
    if (eeprom_clock_out != eck_prev_reg)
      eck_cnt_next = 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_reg <= 8'hff;
      eck_cnt_reg <= 8'hff;
      osc_prev_reg <= 1'b0;
      eck_prev_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      eck_cnt_reg <= eck_cnt_next;
      osc_prev_reg <= oscillator_out;
      eck_prev_reg <= eeprom_clock_out;
    end
  end
  chk_oe_when_on: assert property (master_select [*4] |-> eeprom_select_out_oe)
    else $error("select line not driven while selected");
  chk_data_float: assert property (!master_select [*4] |-> !eeprom_serial_out_oe)
    else $error("data line driven while deselected");
  chk_clock_float: assert property (!master_select [*4] |-> !eeprom_clock_out_oe)
    else $error("memory clock driven while deselected");
  chk_select_float: assert property (!master_select [*4] |-> !eeprom_select_out_oe)
    else $error("memory select driven while deselected");
  chk_fetch_abort: assert property (!master_select [*5] |-> !eeprom_clock_out && !eeprom_select_out)
    else $error("fetch still running while deselected");
  chk_osc_half: assert property (oscillator_out != osc_prev_reg && osc_cnt_reg != 8'hff
    |-> osc_cnt_reg == 8'h7d)
    else $error("oscillator half period wrong");
  chk_clock_high: assert property (!eeprom_clock_out && eck_prev_reg && master_select
    && eck_cnt_reg != 8'hff |-> eck_cnt_reg == 8'h7d)
    else $error("memory clock high phase wrong");
  // The next word selects on the same edge that loads the last one, so look one edge back.
  chk_dac_load: assert property ($changed(offset_dac) || $changed(span_dac)
    |-> !$past(eeprom_select_out))
    else $error("coefficient changed during a fetch");
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  chk_apb_error: assert property (psel && !penable && paddr > 12'h020 |=> pslverr && pready)
    else $error("unmapped access not refused");
  cover property ($rose(eeprom_select_out));
  cover property ($fell(master_select) && eeprom_select_out);
  cover property (pslverr);
endmodule

bind scl_loader scl_loader_checker #(.REFRESH_OSC_CYC(REFRESH_OSC_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .master_select(master_select),
  .eeprom_serial_out_oe(eeprom_serial_out_oe), .eeprom_clock_out(eeprom_clock_out),
  .eeprom_clock_out_oe(eeprom_clock_out_oe), .eeprom_select_out(eeprom_select_out),
  .eeprom_select_out_oe(eeprom_select_out_oe), .oscillator_out(oscillator_out),
  .offset_dac(offset_dac), .span_dac(span_dac)
);

// ### test/scl_eeprom_model.sv
`timescale 1ns/100ps
module scl_eeprom_model (
  // Serial link from the device.
  input wire logic sck,
  input wire logic cs,
  input wire logic din,
  // Serial link to the device.
  output logic dout
);
  // Storage of 256 sixteen-bit words, 4096 bits in all.
  logic [15:0] mem [256];
  logic [7:0] log_q [$];
  logic [11:0] dump = 12'h000;
  logic [10:0] cmd = 11'h000;
  logic [15:0] sh = 16'h0000;
  logic dout_q = 1'b0;
  logic sck_q = 1'b0;
  logic cs_q = 1'b0;
  int n = 0;
  assign dout = dout_q;
  // One process owns all state; a released line shows the inverse of its last bit.
  always @(sck or cs) begin
    if (!cs && cs_q) begin
      n = 0;
      dout_q = ~dout_q;
    end else if (sck && !sck_q) begin
      if (cs) begin
        cmd = {cmd[9:0], din};
        n = n + 1;
        if (n == 11 && cmd[10:8] == 3'h6) begin
          log_q.push_back(cmd[7:0]);
          sh = mem[cmd[7:0]];
        end
      end else begin
        dump = {dump[10:0], din};
      end
    end else if (!sck && sck_q) begin
      if (cs && n >= 11 && n < 27) begin
        dout_q = sh[15];
        sh = {sh[14:0], 1'b0};
      end else if (n == 27) begin
        dout_q = ~dout_q;
      end
    end
    sck_q = sck;
    cs_q = cs;
  end
endmodule

// ### test/scl_loader_test.sv
`timescale 1ns/100ps
module scl_loader_test;
  localparam int REFR = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic master_select = 1'b1;
  logic [11:0] bridge_code = 12'hfff;
  logic bridge_code_valid = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic eeprom_serial_in;
  logic sdo, sdo_oe, sck, sck_oe, scs, scs_oe, osc;
  logic [15:0] ofs, spn, otc, stc, lin;
  logic [2:0] gain;
  logic [31:0] q;
  logic e;
  int mismatches = 0;
  int checks_done = 0;
  wire ee_sck = sck & sck_oe;
  wire ee_cs = scs & scs_oe;
  wire ee_din = sdo & sdo_oe;

  always #20 pclk = ~pclk;

  scl_loader #(.REFRESH_OSC_CYC(REFR)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_select(master_select), .eeprom_serial_in(eeprom_serial_in),
    .eeprom_serial_out(sdo), .eeprom_serial_out_oe(sdo_oe), .eeprom_clock_out(sck),
    .eeprom_clock_out_oe(sck_oe), .eeprom_select_out(scs), .eeprom_select_out_oe(scs_oe),
    .oscillator_out(osc), .bridge_code(bridge_code), .bridge_code_valid(bridge_code_valid),
    .offset_dac(ofs), .span_dac(spn), .offset_tempco_dac(otc), .span_tempco_dac(stc),
    .linearity_dac(lin), .gain_sel(gain)
  );

  scl_eeprom_model u_mem (.sck(ee_sck), .cs(ee_cs), .din(ee_din), .dout(eeprom_serial_in));

  function automatic logic [15:0] mw(input int a);
    return 16'(a * 32'h101) ^ 16'h5a3c;
  endfunction

  function automatic int seg_of(input logic [11:0] c);
    return (int'(c) * 120) >> 12;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16)
      mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    q = 32'h0;
    while (q[2] !== 1'b1 && n < 20000) begin
      apb(1'b0, 12'h004, 32'h0, q, e);
      n++;
    end
    check(32'(q[2]), 32'h1);
  endtask

  // Expected words follow the memory image written at time zero, never the design.
  task automatic check_refresh(input logic [11:0] code);
    int s;
    s = seg_of(code);
    check(32'(u_mem.log_q.size()), 32'h6);
    for (int i = 0; i < u_mem.log_q.size() && i < 6; i++)
      check(32'(u_mem.log_q[i]), 32'(i < 4 ? i : 2 * s + i + 4));
    check(32'(ofs), 32'(mw(1)));
    check(32'(spn), 32'(mw(2)));
    check(32'(lin), 32'(mw(3)));
    check(32'(otc), 32'(mw(8 + 2 * s)));
    check(32'(stc), 32'(mw(9 + 2 * s)));
    check(32'(gain), 32'(mw(0) & 16'h0007));
    check(32'(u_mem.dump), 32'(code));
    apb(1'b0, 12'h004, 32'h0, q, e);
    check(32'(q[14:8]), 32'(s));
    apb(1'b0, 12'h00c, 32'h0, q, e);
    check(q, 32'(mw(1)));
    apb(1'b0, 12'h018, 32'h0, q, e);
    check(q, 32'(mw(9 + 2 * s)));
  endtask

  task automatic summarize();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    int n;
    for (int i = 0; i < 256; i++)
      u_mem.mem[i] = mw(i);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0, q, e);
    check({q[30:0], e}, 32'h2);
    apb(1'b0, 12'h024, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    apb(1'b1, 12'h008, 32'h7, q, e);
    apb(1'b0, 12'h008, 32'h0, q, e);
    check(q, 32'h0);
    // Periodic refresh off until the last step turns it on, so each fetch before then is one that the sequence asked for.
    apb(1'b1, 12'h000, 32'h0, q, e);
    repeat (1000) @(posedge pclk);
    check({30'h0, scs, scs_oe}, 32'h3);
    master_select <= 1'b0;
    repeat (8) @(posedge pclk);
    check({29'h0, sdo_oe, sck_oe, scs_oe}, 32'h0);
    check({30'h0, sck, scs}, 32'h0);
    u_mem.log_q.delete();
    master_select <= 1'b1;
    wait_done();
    check_refresh(12'hfff);
    bridge_code <= 12'h022;
    apb(1'b1, 12'h004, 32'h4, q, e);
    apb(1'b0, 12'h004, 32'h0, q, e);
    check(32'(q[2]), 32'h0);
    u_mem.log_q.delete();
    apb(1'b1, 12'h000, 32'h2, q, e);
    wait_done();
    check_refresh(12'h022);
    apb(1'b1, 12'h000, 32'h1, q, e);
    n = 0;
    while (scs !== 1'b1 && n < 3000) begin
      n++;
      @(posedge pclk);
    end
    check(32'(scs), 32'h1);
    summarize();
  end

  initial begin
    repeat (98000) @(posedge pclk);
    mismatches++;
    summarize();
  end
endmodule
